//--- dwl_pkg.sv
/*
 * Shared constants for the write leveling link: mode register fields,
 * link widths, clock rate and the leveling timing figures.
 * Assumes a 20 MHz system clock shared by both ends of the link.
 */
package dwl_pkg;
    // System clock period in ns.
    localparam int CLK_NS = 50;
    // Mode register select code of the register that holds the leveling bits.
    localparam logic [1:0] MR1_SEL = 2'h1;
    // Bit positions of the leveling enable and the output buffer off bit.
    localparam int WL_BIT = 7;
    localparam int QOFF_BIT = 12;
    // Mode register address width.
    localparam int ADDR_W = 13;
    // Data bits per byte lane, lanes and ranks.
    localparam int LANE_W = 8;
    localparam int LANES = 2;
    localparam int RANKS = 2;
    // Link clock half period and period in system clock cycles.
    localparam int CK_HALF = 4;
    localparam int CK_PER = 2 * CK_HALF;
    localparam int PH_W = $clog2(CK_PER);
    // Timing figures in ns.
    localparam int T_MOD_NS = 600;
    localparam int T_MRD_NS = 200;
    localparam int T_WLDQSEN_NS = 1250;
    localparam int T_DQSL_NS = 100;
    localparam int T_WLMRD_NS = 2000;
    localparam int T_WLO_NS = 450;
    localparam int T_IS_NS = 100;
    localparam int T_AOF_NS = 400;
    // Width of the wait counters.
    localparam int CNT_W = 8;
    // Least times round up to whole cycles.
    localparam logic [7:0] T_MOD_CYC = 8'((T_MOD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] T_MRD_CYC = 8'((T_MRD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] T_WLDQSEN_CYC = 8'((T_WLDQSEN_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] T_DQSL_CYC = 8'((T_DQSL_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] T_WLMRD_CYC = 8'((T_WLMRD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] T_OFF_CYC = 8'((T_AOF_NS + T_IS_NS + CLK_NS - 1) / CLK_NS);
    // The feedback deadline is a longest time and rounds down.
    localparam logic [7:0] T_WLO_CYC = 8'(T_WLO_NS / CLK_NS);
endpackage

//--- dwl_link_if.sv
/*
 * Link between the leveling controller and the memory device.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface dwl_link_if #(
    parameter int LANES = dwl_pkg::LANES,
    parameter int RANKS = dwl_pkg::RANKS
);
    logic ck;                                   // Link clock level.
    logic mrsStb;                               // Mode register write, else no-op.
    logic [RANKS-1:0] rankSel;                  // Ranks addressed by the write.
    logic [1:0] mrSel;                          // Mode register select.
    logic [dwl_pkg::ADDR_W-1:0] mrAddr;         // Mode register value.
    logic odt;                                  // Termination control.
    logic [LANES-1:0] dqsOut;                   // True strobe per lane.
    logic [LANES-1:0] dqsNOut;                  // Complement strobe per lane.
    logic dqsOe;                                // Controller drives the strobes.
    logic [LANES*dwl_pkg::LANE_W-1:0] dqOut;    // Data driven by the device.
    logic dqOe;                                 // Device drives the data pins.
    logic dqUndef;                              // Data pins hold no defined value.

    // Controller end.
    modport ctl (
        output ck, mrsStb, rankSel, mrSel, mrAddr, odt, dqsOut, dqsNOut, dqsOe,
        input dqOut, dqOe, dqUndef
    );
    // Memory device end.
    modport dev (
        input ck, mrsStb, rankSel, mrSel, mrAddr, odt, dqsOut, dqsNOut, dqsOe,
        output dqOut, dqOe, dqUndef
    );
endinterface

//--- dwl_dram_end.sv
/*
 * Memory device end of write leveling: mode bits, termination, strobe
 * sampling of the link clock and feedback on the prime bit of each lane.
 * Assumes the controller keeps its side of the leveling procedure.
 */
`timescale 1ns/1ps
module dwl_dram_end #(
    parameter int MY_RANK = 0,
    parameter int LANES = dwl_pkg::LANES
) (
    input wire logic mclk,
    input wire logic rst_n,
    dwl_link_if.dev link,
    output logic wlActive,
    output logic outputsOff,
    output logic termDqs,
    output logic termDq
);
    ////////////////////////////////////////////////////////////////////////
    logic mrsHit;                       // Write to this rank's leveling register.
    logic wl_r;                         // Leveling mode flag.
    logic qoff_r;                       // Output buffer disabled.
    logic exiting_r;                    // Exit window still running.
    logic [7:0] exitCnt_r;              // Cycles left in the exit window.
    logic fbReady_r;                    // A feedback sample has been taken.
    logic [LANES-1:0] dqsPrev_r;        // Strobe level seen last cycle.
    logic [LANES-1:0] fb_r;             // Sampled clock level per lane.

    // A write counts only when addressed to this rank and register.
    assign mrsHit = link.mrsStb && link.rankSel[MY_RANK] && (link.mrSel == dwl_pkg::MR1_SEL);

    ////////////////////////////////////////////////////////////////////////
    // Mode bits follow every write to the register.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wl_r <= 1'b0;
            qoff_r <= 1'b0;
        end
        else if (mrsHit)
        begin
            wl_r <= link.mrAddr[dwl_pkg::WL_BIT];
            qoff_r <= link.mrAddr[dwl_pkg::QOFF_BIT];
        end
    end

    // Termination: during leveling the pin switches only the strobe pair.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            termDqs <= 1'b0;
            termDq <= 1'b0;
        end
        else
        begin
            termDqs <= link.odt;
            termDq <= link.odt && !wl_r;
        end
    end

    // Data stays undefined for the exit window after leaving the mode.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            exiting_r <= 1'b0;
            exitCnt_r <= 8'h00;
        end
        else if (mrsHit && wl_r && !link.mrAddr[dwl_pkg::WL_BIT])
        begin
            exiting_r <= 1'b1;
            exitCnt_r <= dwl_pkg::T_MOD_CYC;
        end
        else if (exitCnt_r > 8'h01)
        begin
            exitCnt_r <= exitCnt_r - 8'h01;
        end
        else
        begin
            exiting_r <= 1'b0;
            exitCnt_r <= 8'h00;
        end
    end

    // Feedback is undefined from entry until the first strobe sample.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fbReady_r <= 1'b0;
        end
        else if (mrsHit && link.mrAddr[dwl_pkg::WL_BIT] && !wl_r)
        begin
            fbReady_r <= 1'b0;
        end
        else if (wl_r && |(link.dqsOut & ~dqsPrev_r & {LANES{link.dqsOe}}))
        begin
            fbReady_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Each lane samples the clock on its own rising strobe edge.
    genvar l;
    generate
        for (l = 0; l < LANES; l++)
        begin : g_lane
            always_ff @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    dqsPrev_r[l] <= 1'b0;
                    fb_r[l] <= 1'b0;
                end
                else
                begin
                    dqsPrev_r[l] <= link.dqsOe && link.dqsOut[l];
                    if (wl_r && link.dqsOe && link.dqsOut[l] && !dqsPrev_r[l])
                    begin
                        fb_r[l] <= link.ck;
                    end
                end
            end
            // Only the prime bit carries feedback; the rest stay low.
            assign link.dqOut[l*dwl_pkg::LANE_W] = fb_r[l];
            assign link.dqOut[l*dwl_pkg::LANE_W+dwl_pkg::LANE_W-1 -: dwl_pkg::LANE_W-1] =
                '0;
        end
    endgenerate

    // Data pins drive in leveling and its exit window unless outputs are off.
    assign link.dqOe = !qoff_r && (wl_r || exiting_r);
    assign link.dqUndef = (wl_r && !fbReady_r) || exiting_r;
    assign wlActive = wl_r;
    assign outputsOff = qoff_r;
endmodule

//--- dwl_ctrl_end.sv
/*
 * Controller end of write leveling: drives the link clock, mode writes,
 * termination and strobes, and sweeps each lane's strobe delay until the
 * feedback turns from low to high.
 * Assumes the device answers within the feedback deadline on the prime bits.
 */
`timescale 1ns/1ps
module dwl_ctrl_end #(
    parameter int LANES = dwl_pkg::LANES,
    parameter int RANKS = dwl_pkg::RANKS,
    parameter int RANK_W = 1
) (
    input wire logic mclk,
    input wire logic rst_n,
    dwl_link_if.ctl link,
    input wire logic start,
    input wire logic [RANK_W-1:0] targetRank,
    output logic busy,
    output logic done,
    output logic mrsReady,
    output logic [LANES-1:0][dwl_pkg::PH_W-1:0] lockDelay
);
    ////////////////////////////////////////////////////////////////////////
    // Sequence states, one-hot.
    typedef enum logic [12:0] {
        S_IDLE   = 13'h0001,
        S_OFFRK  = 13'h0002,
        S_ENTER  = 13'h0004,
        S_ODTON  = 13'h0008,
        S_DQSLO  = 13'h0010,
        S_ALIGN  = 13'h0020,
        S_PULSE  = 13'h0040,
        S_WFB    = 13'h0080,
        S_STEP   = 13'h0100,
        S_EXDQS  = 13'h0200,
        S_ODTOFF = 13'h0400,
        S_EXMRS  = 13'h0800,
        S_SPARE  = 13'h1000
    } dwl_ctl_state_type;

    dwl_ctl_state_type state_r;             // Current state.
    dwl_ctl_state_type stateNxt;            // Next state.
    logic [dwl_pkg::CNT_W-1:0] cnt_r;       // Cycles spent in the state.
    logic [dwl_pkg::CNT_W-1:0] cntNxt;      // Next count.
    logic [dwl_pkg::PH_W-1:0] phase_r;      // Link clock phase.
    logic [dwl_pkg::PH_W-1:0] phaseNxt;     // Next phase.
    logic [RANKS-1:0] tgtMask;              // One-hot target rank.
    logic [RANK_W-1:0] tgt_r;               // Rank being leveled.
    logic [LANES-1:0] locked_r;             // Lane delay is fixed.
    logic [LANES-1:0] prevFb_r;             // Feedback seen at the last pulse.
    logic [LANES-1:0] fbNow;                // Feedback on the prime bits.
    logic [LANES-1:0] hit;                  // Low-to-high seen this pulse.
    logic allLocked;                        // Every lane is fixed.
    logic entering;                         // A new state starts next cycle.
    logic [dwl_pkg::CNT_W-1:0] dqsWait;     // Strobe low plus strobe delay.

    // While idle the mask follows the request, so the first write already
    // spares the rank that is about to be leveled.
    assign tgtMask = RANKS'(1) << ((state_r == S_IDLE) ? targetRank : tgt_r);
    assign entering = (stateNxt != state_r);
    assign cntNxt = entering ? '0 : cnt_r + 1'b1;
    assign phaseNxt = phase_r + 1'b1;
    assign dqsWait = dwl_pkg::T_DQSL_CYC + dwl_pkg::T_WLMRD_CYC;
    assign allLocked = &(locked_r | hit);
    assign busy = (state_r != S_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // Next state; between mode writes the command lines idle as no-ops.
    always_comb
    begin
        stateNxt = state_r;
        case (state_r)
            S_IDLE:   if (start) stateNxt = S_OFFRK;
            S_OFFRK:  if (cnt_r == dwl_pkg::T_MRD_CYC) stateNxt = S_ENTER;
            S_ENTER:  if (cnt_r == dwl_pkg::T_MOD_CYC) stateNxt = S_ODTON;
            S_ODTON:  if (cnt_r == dwl_pkg::T_WLDQSEN_CYC) stateNxt = S_DQSLO;
            S_DQSLO:  if (cnt_r == dqsWait) stateNxt = S_ALIGN;
            S_ALIGN:  if (phase_r == dwl_pkg::PH_W'(dwl_pkg::CK_PER - 1)) stateNxt = S_PULSE;
            S_PULSE:
            begin
                if (cnt_r == dwl_pkg::CNT_W'(dwl_pkg::CK_PER - 1))
                begin
                    stateNxt = S_WFB;
                end
            end
            S_WFB:    if (cnt_r == dwl_pkg::T_WLO_CYC) stateNxt = S_STEP;
            S_STEP:   stateNxt = allLocked ? S_EXDQS : S_DQSLO;
            S_EXDQS:  stateNxt = S_ODTOFF;
            S_ODTOFF: if (cnt_r == dwl_pkg::T_OFF_CYC) stateNxt = S_EXMRS;
            S_EXMRS:  if (cnt_r == dwl_pkg::T_MOD_CYC) stateNxt = S_IDLE;
            default:  stateNxt = S_IDLE;
        endcase
    end

    // State and wait counter.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= S_IDLE;
            cnt_r <= '0;
        end
        else
        begin
            state_r <= stateNxt;
            cnt_r <= cntNxt;
        end
    end

    // Target rank is caught at start.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tgt_r <= '0;
        end
        else if (state_r == S_IDLE && start)
        begin
            tgt_r <= targetRank;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Free running link clock from the phase divider.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_r <= '0;
            link.ck <= 1'b1;
        end
        else
        begin
            phase_r <= phaseNxt;
            link.ck <= (phaseNxt < dwl_pkg::PH_W'(dwl_pkg::CK_HALF));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode writes, one cycle at the start of each writing state.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            link.mrsStb <= 1'b0;
            link.rankSel <= '0;
            link.mrSel <= '0;
            link.mrAddr <= '0;
        end
        else
        begin
            link.mrsStb <= entering && (stateNxt inside {S_OFFRK, S_ENTER, S_EXMRS});
            link.mrSel <= dwl_pkg::MR1_SEL;
            link.mrAddr <= '0;
            link.rankSel <= tgtMask;
            if (stateNxt == S_OFFRK)
            begin
                // Other ranks get their outputs switched off.
                link.rankSel <= ~tgtMask;
                link.mrAddr[dwl_pkg::QOFF_BIT] <= 1'b1;
            end
            else if (stateNxt == S_ENTER)
            begin
                // Output buffer stays on, so termination is left at its nominal value.
                link.mrAddr[dwl_pkg::WL_BIT] <= 1'b1;
            end
        end
    end

    // Termination and strobe enable follow the sequence.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            link.odt <= 1'b0;
            link.dqsOe <= 1'b0;
        end
        else
        begin
            link.odt <= (stateNxt inside {S_ODTON, S_DQSLO, S_ALIGN, S_PULSE, S_WFB,
                S_STEP, S_EXDQS});
            link.dqsOe <= (stateNxt inside {S_DQSLO, S_ALIGN, S_PULSE, S_WFB,
                S_STEP});
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per lane strobe, feedback check and delay sweep.
    genvar l;
    generate
        for (l = 0; l < LANES; l++)
        begin : g_lane
            assign fbNow[l] = link.dqOut[l*dwl_pkg::LANE_W];
            assign hit[l] = !locked_r[l] && !prevFb_r[l] && fbNow[l];

            // One rising edge per pulse, at the lane's delay from clock rise.
            always_ff @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    link.dqsOut[l] <= 1'b0;
                    link.dqsNOut[l] <= 1'b1;
                end
                else
                begin
                    link.dqsOut[l] <= (stateNxt == S_PULSE)
                        && (cntNxt >= dwl_pkg::CNT_W'(lockDelay[l]));
                    link.dqsNOut[l] <= !((stateNxt == S_PULSE)
                        && (cntNxt >= dwl_pkg::CNT_W'(lockDelay[l])));
                end
            end

            // Step the delay until feedback turns from low to high.
            always_ff @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    lockDelay[l] <= '0;
                    locked_r[l] <= 1'b0;
                    prevFb_r[l] <= 1'b1;
                end
                else if (state_r == S_IDLE && start)
                begin
                    lockDelay[l] <= '0;
                    locked_r[l] <= 1'b0;
                    prevFb_r[l] <= 1'b1;
                end
                else if (state_r == S_STEP && !locked_r[l])
                begin
                    prevFb_r[l] <= fbNow[l];
                    if (hit[l])
                    begin
                        locked_r[l] <= 1'b1;
                    end
                    else
                    begin
                        lockDelay[l] <= lockDelay[l] + 1'b1;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Exit status: register writes allowed after the short delay, done after the long one.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mrsReady <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            mrsReady <= (stateNxt == S_EXMRS) && (cntNxt >= dwl_pkg::T_MRD_CYC);
            done <= (state_r == S_EXMRS) && (stateNxt == S_IDLE);
        end
    end
endmodule

//--- dwl_link_chk.sv
/*
 * Checker for the write leveling link; it watches the link signals only.
 * Assumes the device end under watch answers to rank 0.
 */
`timescale 1ns/1ps
module dwl_link_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ck,
    input wire logic mrsStb,
    input wire logic [dwl_pkg::RANKS-1:0] rankSel,
    input wire logic [1:0] mrSel,
    input wire logic [dwl_pkg::ADDR_W-1:0] mrAddr,
    input wire logic odt,
    input wire logic [dwl_pkg::LANES-1:0] dqsOut,
    input wire logic [dwl_pkg::LANES-1:0] dqsNOut,
    input wire logic dqsOe,
    input wire logic [dwl_pkg::LANES*dwl_pkg::LANE_W-1:0] dqOut,
    input wire logic dqOe,
    input wire logic dqUndef
);
    localparam logic [15:0] PRIME = 16'h0101; // Feedback bits of both lanes.
    logic [7:0] sinceMrs_r; // Cycles since the last mode write.
    logic [7:0] odtHigh_r; // Cycles with termination requested.
    logic [7:0] odtLow_r; // Cycles with termination released.
    logic [7:0] oeHigh_r; // Cycles with the strobes driven.
    logic writeOwn; // Mode write aimed at the watched rank.

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    assign writeOwn = mrsStb && rankSel[0] && (mrSel == dwl_pkg::MR1_SEL);

    // Counts saturate so that a long quiet span never wraps into a short one.
    function automatic logic [7:0] sat(input logic [7:0] v);
        return (v == 8'hFF) ? v : v + 8'h01;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Spacing of mode writes.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            sinceMrs_r <= 8'hFF;
        else
            sinceMrs_r <= mrsStb ? 8'h01 : sat(sinceMrs_r);
    end

    // Lengths of the termination and strobe drive levels.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            odtHigh_r <= 8'h00;
            odtLow_r <= 8'hFF;
            oeHigh_r <= 8'h00;
        end
        else
        begin
            odtHigh_r <= odt ? sat(odtHigh_r) : 8'h00;
            odtLow_r <= odt ? 8'h00 : sat(odtLow_r);
            oeHigh_r <= dqsOe ? sat(oeHigh_r) : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // The exit write and the undefined span that follows it.
    sequence exitWrite;
        writeOwn && !mrAddr[dwl_pkg::WL_BIT];
    endsequence
    sequence undefHold;
        dqUndef[*8] ##1 dqUndef[*4];
    endsequence

    a_entry_drives_data: assert property (
        writeOwn && mrAddr[dwl_pkg::WL_BIT] && !mrAddr[dwl_pkg::QOFF_BIT] |=> dqOe && dqUndef)
        else $error("data not driven undefined after entry");
    a_nonprime_bits_low: assert property ((dqOut & ~PRIME) == '0)
        else $error("non-prime data bit high");
    a_no_write_strobing: assert property (dqsOe |-> !mrsStb)
        else $error("mode write while strobes driven");
    a_odt_after_mod: assert property ($rose(odt) |-> sinceMrs_r >= dwl_pkg::T_MOD_CYC)
        else $error("termination requested too early");
    a_strobe_after_term: assert property (
        $rose(dqsOe) |-> odt && odtHigh_r >= dwl_pkg::T_WLDQSEN_CYC)
        else $error("strobes driven before termination delay");
    a_strobe_pair_opposite: assert property (dqsOe |-> dqsNOut == ~dqsOut)
        else $error("strobe pair not complementary");
    a_first_edge_wait: assert property (
        $rose(dqsOut[0]) |-> dqsOe && oeHigh_r >= dwl_pkg::T_DQSL_CYC
        && sinceMrs_r >= dwl_pkg::T_WLMRD_CYC)
        else $error("strobe edge before low time and delay");
    a_lane0_feedback: assert property (
        dqsOe && $rose(dqsOut[0]) |=> dqOut[0] == $past(ck))
        else $error("lane 0 feedback differs from sampled clock");
    a_lane1_feedback: assert property (
        dqsOe && $rose(dqsOut[1]) |=> dqOut[8] == $past(ck))
        else $error("lane 1 feedback differs from sampled clock");
    a_exit_after_odt: assert property (
        exitWrite |-> !odt && odtLow_r >= dwl_pkg::T_OFF_CYC)
        else $error("exit write before termination off");
    a_exit_data_undef: assert property (exitWrite |=> undefHold)
        else $error("data defined too soon after exit");
    a_mode_write_gap: assert property (mrsStb |-> sinceMrs_r >= dwl_pkg::T_MRD_CYC)
        else $error("mode writes too close");
endmodule

//--- testbench.sv
/*
 * Self-checking bench: controller and rank 0 device joined by the link.
 * Assumes a 20 MHz clock and the default link parameters.
 */
`timescale 1ns/1ps
module testbench;
    logic mclk = 1'h0; // System clock.
    logic rst_n = 1'h0; // Reset, active low.
    logic start = 1'h0; // Leveling request.
    logic [0:0] targetRank = 1'h0; // Rank to level.
    logic busy, done, mrsReady, wlActive, outputsOff, termDqs, termDq;
    logic [dwl_pkg::LANES-1:0][dwl_pkg::PH_W-1:0] lockDelay; // Locked delays.
    int miscompares = 0; // Mismatches seen.
    int checked = 0; // Comparisons made.
    // The clock is first seen high at phase 0, so that is the first low-to-high point.
    localparam logic [5:0] LOCK_EXP = 6'h00;

`define CHECK(got, exp) \
    begin \
        checked++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("mismatch at %0t got %0h expected %0h", $time, got, exp); \
        end \
    end

    dwl_link_if link();
    dwl_ctrl_end dwl_ctrl_end_i (.mclk(mclk), .rst_n(rst_n), .link(link.ctl), .start(start),
        .targetRank(targetRank), .busy(busy), .done(done), .mrsReady(mrsReady),
        .lockDelay(lockDelay));
    dwl_dram_end #(.MY_RANK(0)) dwl_dram_end_i (.mclk(mclk), .rst_n(rst_n),
        .link(link.dev), .wlActive(wlActive), .outputsOff(outputsOff), .termDqs(termDqs),
        .termDq(termDq));
    dwl_link_chk dwl_link_chk_i (.mclk(mclk), .rst_n(rst_n), .ck(link.ck),
        .mrsStb(link.mrsStb), .rankSel(link.rankSel), .mrSel(link.mrSel),
        .mrAddr(link.mrAddr), .odt(link.odt), .dqsOut(link.dqsOut), .dqsNOut(link.dqsNOut),
        .dqsOe(link.dqsOe), .dqOut(link.dqOut), .dqOe(link.dqOe), .dqUndef(link.dqUndef));

    // The clock toggles every half period.
    always #25 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Tells whether the awaited event shows in the current cycle.
    function automatic logic hit(input int sel);
        case (sel)
            0: return link.mrsStb === 1'h1;
            1: return link.odt === 1'h1;
            2: return link.dqsOe === 1'h1;
            3: return done === 1'h1;
            default: return mrsReady === 1'h1;
        endcase
    endfunction

    // Steps falling edges until the event shows; a long wait counts as a mismatch.
    task automatic step_until(input int sel);
        int n;
        n = 0;
        // The event may already stand, so it is tested before each step.
        while (!hit(sel) && n < 3000)
        begin
            @(negedge mclk);
            n++;
        end
        if (n >= 3000)
            miscompares++;
    endtask

    // One full leveling run of rank 0, with a refused request in mid-run.
    task automatic level_run();
        @(negedge mclk);
        start = 1'h1;
        targetRank = 1'h0;
        @(negedge mclk);
        start = 1'h0;
        `CHECK(busy, 1'h1)
        step_until(0);
        `CHECK(link.rankSel, 2'h2)
        `CHECK(link.mrAddr[dwl_pkg::QOFF_BIT], 1'h1)
        @(negedge mclk);
        step_until(0);
        `CHECK(link.rankSel, 2'h1)
        `CHECK(link.mrAddr[dwl_pkg::WL_BIT], 1'h1)
        @(negedge mclk);
        `CHECK(wlActive, 1'h1)
        `CHECK(outputsOff, 1'h0)
        `CHECK(link.dqOe, 1'h1)
        `CHECK(link.dqUndef, 1'h1)
        step_until(1);
        start = 1'h1;
        @(negedge mclk);
        start = 1'h0;
        `CHECK(link.mrsStb, 1'h0)
        `CHECK(termDqs, 1'h1)
        `CHECK(termDq, 1'h0)
        step_until(2);
        `CHECK(link.dqsOut, 2'h0)
        `CHECK(link.dqsNOut, 2'h3)
        step_until(4);
        `CHECK(done, 1'h0)
        `CHECK(wlActive, 1'h0)
        `CHECK(link.dqUndef, 1'h1)
        step_until(3);
        `CHECK(lockDelay, LOCK_EXP)
        repeat (2) @(negedge mclk);
        `CHECK(busy, 1'h0)
        `CHECK(wlActive, 1'h0)
        `CHECK(termDqs, 1'h0)
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, then two runs back to back.
    initial
    begin
        repeat (3) @(negedge mclk);
        rst_n = 1'h1;
        level_run();
        level_run();
        wrap_up();
    end

    // Two runs take about thirteen hundred cycles; twenty thousand means a hang.
    initial
    begin
        #1000000;
        miscompares++;
        wrap_up();
    end
endmodule
